// ---- sfb_defs.vh ----
// constants for the serial flash buffer command sequencer
`ifndef SFB_DEFS_VH
`define SFB_DEFS_VH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define SFB_OP_RD_B1_A    8'h54
`define SFB_OP_RD_B1_B    8'hd4
`define SFB_OP_RD_B2_A    8'h56
`define SFB_OP_RD_B2_B    8'hd6
`define SFB_OP_STAT_A     8'h57
`define SFB_OP_STAT_B     8'hd7
`define SFB_OP_WR_B1      8'h84
`define SFB_OP_WR_B2      8'h87
`define SFB_OP_PGE_B1     8'h83
`define SFB_OP_PGE_B2     8'h86
`define SFB_OP_PGM_B1     8'h88
`define SFB_OP_PGM_B2     8'h89
`define SFB_OP_PAGE_ERA   8'h81
`define SFB_OP_BLK_ERA    8'h50
`define SFB_OP_THRU_B1    8'h82
`define SFB_OP_THRU_B2    8'h85

// ----------------------------------------------------------------
// frame layout, counted in received bits
// ----------------------------------------------------------------
`define SFB_OPC_BITS      6'd8
`define SFB_ADDR_END      6'd32
`define SFB_RD_DATA_BIT   6'd40
`define SFB_BYTE_ADDR_LSB 0
`define SFB_PAGE_LSB      9
`define SFB_THRU_PAGE_LSB 9
`define SFB_BLK_LSB       12
`define SFB_BUF_LAST      9'd263
`define SFB_BUF_SIZE      10'd264

// ----------------------------------------------------------------
// status register layout
// ----------------------------------------------------------------
`define SFB_ST_READY      7
`define SFB_ST_COMP       6
`define SFB_ST_RESERVED   2'b00

// ----------------------------------------------------------------
// array operation codes to the array controller
// ----------------------------------------------------------------
`define SFB_ARR_NONE      3'h0
`define SFB_ARR_PGM_ERA   3'h1
`define SFB_ARR_PGM       3'h2
`define SFB_ARR_PAGE_ERA  3'h3
`define SFB_ARR_BLK_ERA   3'h4

// ----------------------------------------------------------------
// timing: busy times in microseconds, clock in MHz
// ----------------------------------------------------------------
`define SFB_CLK_MHZ       250
`define SFB_T_EP_US       20000
`define SFB_T_P_US        14000
`define SFB_T_PE_US       8000
`define SFB_T_BE_US       12000

`endif

// ---- sfb_sync.v ----
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module sfb_sync #(
   parameter INIT = 1'b0
) (
   input  wire ref_clk_in,
   input  wire reset_n_in,
   input  wire pin_in,
   output reg  level_out,
   output reg  rise_out,
   output reg  fall_out
);
   reg s1_q;
   reg s2_q;
   reg s3_q;

   // ----------------------------------------------------------------
   // sampling chain; s1 feeds only s2 to limit metastability
   // ----------------------------------------------------------------
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s1_q      <= INIT;
         s2_q      <= INIT;
         s3_q      <= INIT;
         level_out <= INIT;
         rise_out  <= 1'b0;
         fall_out  <= 1'b0;
      end else begin
         s1_q     <= pin_in;
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         rise_out <= 1'b0;
         fall_out <= 1'b0;
         // a change counts only once stages two and three agree
         if (s2_q == s3_q && s3_q != level_out) begin
            level_out <= s3_q;
            rise_out  <= s3_q;
            fall_out  <= ~s3_q;
         end
      end
   end
endmodule

// ---- sfb_busy_timer.v ----
// self-timed busy counter for program and erase operations
`timescale 1ns/1ps
module sfb_busy_timer (
   input  wire        ref_clk_in,
   input  wire        reset_n_in,
   input  wire        start_in,
   input  wire [31:0] cycles_in,
   output reg         busy_out,
   output reg         done_out
);
   reg [31:0] cnt_q;

   // ----------------------------------------------------------------
   // count down from the loaded time; done pulses at the edge that drops busy
   // ----------------------------------------------------------------
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q    <= 32'h0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (start_in && !busy_out) begin
            cnt_q    <= cycles_in;
            busy_out <= 1'b1;
         end else if (busy_out) begin
            if (cnt_q <= 32'h1) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
               cnt_q    <= 32'h0;
            end else begin
               cnt_q <= cnt_q - 32'h1;
            end
         end
      end
   end
endmodule

// ---- sfb_top.v ----
// serial flash buffer, status and program/erase command sequencer
//
// Notes on behaviour
// - buffer read opcodes 54h/d4h pick buffer one, 56h/d6h buffer two.
// - read frame: opcode, 15 dummy, nine-bit byte address, eight dummy, then data.
// - read streams consecutive buffer bytes, wrapping from byte 263 to zero.
// - chip select rising ends any read and floats the output at once.
// - status opcodes 57h/d7h shift status out msb first after the opcode.
// - status repeats from bit 7 with fresh contents while clocking continues.
// - with clock parked after bit 7, output follows ready live, zero to one.
// - busy only for array operations, never for buffer or status commands.
// - bits 5..2 hold a fixed density code; low bits reserved.
// - buffer write opcodes 84h/87h, 15 dummy, nine-bit address, then data.
// - written bytes go to incrementing addresses, wrapping, until select rises.
// - 83h/86h erase then program the page from a buffer, busy erase-program time.
// - 88h/89h program an erased page from a buffer, busy program time.
// - 81h erases one page to ones, busy page erase time.
// - 50h erases an eight-page block to ones, busy block erase time.
// - 82h/85h fill a buffer with page and start address, then erase-program.
// - every command starts on select falling; bits move with the clock.
// - all bits travel most significant first.
`timescale 1ns/1ps
`include "sfb_defs.vh"
module sfb_top #(
   parameter [31:0] EP_CYCLES = `SFB_T_EP_US * `SFB_CLK_MHZ,
   parameter [31:0] P_CYCLES  = `SFB_T_P_US * `SFB_CLK_MHZ,
   parameter [31:0] PE_CYCLES = `SFB_T_PE_US * `SFB_CLK_MHZ,
   parameter [31:0] BE_CYCLES = `SFB_T_BE_US * `SFB_CLK_MHZ,
   // density code value is arbitrary
   parameter [3:0]  DENSITY_CODE = 4'ha
) (
   input  wire       ref_clk_in,
   input  wire       reset_n_in,
   input  wire       cs_n_in,
   input  wire       sck_in,
   input  wire       si_in,
   output reg        so_out,
   output reg        so_oe_out,
   input  wire       cmp_done_in,
   input  wire       cmp_mismatch_in,
   input  wire [8:0] arr_buf_addr_in,
   input  wire       arr_buf_sel_in,
   output reg  [7:0] arr_buf_data_out,
   output reg        arr_start_out,
   output reg  [2:0] arr_op_out,
   output reg  [9:0] arr_page_out,
   output reg        arr_buf_out,
   output reg        busy_out
);
   // ----------------------------------------------------------------
   // states, one-hot
   // ----------------------------------------------------------------
   localparam [6:0] ST_IDLE = 7'b0000001;
   localparam [6:0] ST_OPC  = 7'b0000010;
   localparam [6:0] ST_RBUF = 7'b0000100;
   localparam [6:0] ST_STAT = 7'b0001000;
   localparam [6:0] ST_WBUF = 7'b0010000;
   localparam [6:0] ST_ARR  = 7'b0100000;
   localparam [6:0] ST_IGN  = 7'b1000000;

   wire        cs_n_lvl;
   wire        cs_rise;
   wire        cs_fall;
   wire        sck_rise;
   wire        sck_fall;
   wire        si_lvl;
   wire        tmr_busy;
   wire        tmr_done;
   wire [7:0]  status;
   wire [7:0]  opc_next;

   reg  [6:0]  state_q;
   reg  [7:0]  opc_q;
   reg  [5:0]  bit_cnt_q;
   reg  [23:0] sr_q;
   reg  [9:0]  page_q;
   reg  [8:0]  baddr_q;
   reg         bsel_q;
   reg  [2:0]  out_idx_q;
   reg  [7:0]  out_byte_q;
   reg         out_on_q;
   reg         show_rdy_q;
   reg         comp_q;
   reg  [7:0]  rd_data_q;
   reg         tmr_start_q;
   reg  [31:0] tmr_cycles_q;
   reg  [7:0]  buf_mem [0:527];

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // flat index into the two 264-byte buffers
   function [9:0] buf_index;
      input       sel;
      input [8:0] addr;
      begin
         buf_index = {1'b0, addr} + (sel ? `SFB_BUF_SIZE : 10'd0);
      end
   endfunction

   // opcode to state; unknown codes fall into the ignore state
   function [6:0] opc_state;
      input [7:0] opc;
      begin
         case (opc)
            `SFB_OP_RD_B1_A, `SFB_OP_RD_B1_B,
            `SFB_OP_RD_B2_A, `SFB_OP_RD_B2_B: opc_state = ST_RBUF;
            `SFB_OP_STAT_A, `SFB_OP_STAT_B:   opc_state = ST_STAT;
            `SFB_OP_WR_B1, `SFB_OP_WR_B2:     opc_state = ST_WBUF;
            `SFB_OP_THRU_B1, `SFB_OP_THRU_B2: opc_state = ST_WBUF;
            `SFB_OP_PGE_B1, `SFB_OP_PGE_B2, `SFB_OP_PGM_B1, `SFB_OP_PGM_B2,
            `SFB_OP_PAGE_ERA, `SFB_OP_BLK_ERA: opc_state = ST_ARR;
            default:                          opc_state = ST_IGN;
         endcase
      end
   endfunction

   // buffer chosen by an opcode
   function buf_of;
      input [7:0] opc;
      begin
         buf_of = (opc == `SFB_OP_RD_B2_A) || (opc == `SFB_OP_RD_B2_B) ||
                  (opc == `SFB_OP_WR_B2) || (opc == `SFB_OP_PGE_B2) ||
                  (opc == `SFB_OP_PGM_B2) || (opc == `SFB_OP_THRU_B2);
      end
   endfunction

   function [8:0] next_addr;
      input [8:0] addr;
      begin
         next_addr = (addr == `SFB_BUF_LAST) ? 9'd0 : addr + 9'd1;
      end
   endfunction

   assign opc_next = {opc_q[6:0], si_lvl};
   // ready, compare result, density code, reserved low bits
   assign status   = {~tmr_busy, comp_q, DENSITY_CODE, `SFB_ST_RESERVED};

   // ----------------------------------------------------------------
   // pin synchronisers and busy timer
   // ----------------------------------------------------------------
   sfb_sync #(.INIT(1'b1)) u_cs_sync (
      .ref_clk_in (ref_clk_in),
      .reset_n_in (reset_n_in),
      .pin_in     (cs_n_in),
      .level_out  (cs_n_lvl),
      .rise_out   (cs_rise),
      .fall_out   (cs_fall)
   );

   sfb_sync #(.INIT(1'b0)) u_sck_sync (
      .ref_clk_in (ref_clk_in),
      .reset_n_in (reset_n_in),
      .pin_in     (sck_in),
      .level_out  (),
      .rise_out   (sck_rise),
      .fall_out   (sck_fall)
   );

   // same depth as the clock path, so data lines up with the edge
   sfb_sync #(.INIT(1'b0)) u_si_sync (
      .ref_clk_in (ref_clk_in),
      .reset_n_in (reset_n_in),
      .pin_in     (si_in),
      .level_out  (si_lvl),
      .rise_out   (),
      .fall_out   ()
   );

   sfb_busy_timer u_timer (
      .ref_clk_in (ref_clk_in),
      .reset_n_in (reset_n_in),
      .start_in   (tmr_start_q),
      .cycles_in  (tmr_cycles_q),
      .busy_out   (tmr_busy),
      .done_out   (tmr_done)
   );

   // ----------------------------------------------------------------
   // buffer memories: host writes, read prefetch, array-side port
   // ----------------------------------------------------------------
   always @(posedge ref_clk_in) begin
      rd_data_q        <= buf_mem[buf_index(bsel_q, baddr_q)];
      arr_buf_data_out <= buf_mem[buf_index(arr_buf_sel_in, arr_buf_addr_in)];
      // a full byte landed; store it at the running address
      if (state_q == ST_WBUF && sck_rise && !cs_n_lvl &&
          bit_cnt_q == `SFB_RD_DATA_BIT - 6'd1) begin
         buf_mem[buf_index(bsel_q, baddr_q)] <= {sr_q[6:0], si_lvl};
      end
   end

   // ----------------------------------------------------------------
   // compare result holds until the next compare finishes
   // ----------------------------------------------------------------
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         comp_q <= 1'b0;
      end else if (cmp_done_in) begin
         comp_q <= cmp_mismatch_in;
      end
   end

   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_q      <= ST_IDLE;
         opc_q        <= 8'h00;
         bit_cnt_q    <= 6'd0;
         sr_q         <= 24'h0;
         page_q       <= 10'd0;
         baddr_q      <= 9'd0;
         bsel_q       <= 1'b0;
         out_idx_q    <= 3'd0;
         out_byte_q   <= 8'h00;
         out_on_q     <= 1'b0;
         show_rdy_q   <= 1'b0;
         so_out       <= 1'b0;
         so_oe_out    <= 1'b0;
         tmr_start_q  <= 1'b0;
         tmr_cycles_q <= 32'h0;
         arr_start_out <= 1'b0;
         arr_op_out   <= `SFB_ARR_NONE;
         arr_page_out <= 10'd0;
         arr_buf_out  <= 1'b0;
         busy_out     <= 1'b0;
      end else begin
         tmr_start_q   <= 1'b0;
         arr_start_out <= 1'b0;
         busy_out      <= tmr_busy;
         so_oe_out     <= out_on_q;
         if (cs_rise) begin
            // select rising ends the frame and floats the output
            state_q    <= ST_IDLE;
            out_on_q   <= 1'b0;
            so_oe_out  <= 1'b0;
            show_rdy_q <= 1'b0;
            // array work starts only on a complete frame, one at a time
            if (bit_cnt_q >= `SFB_ADDR_END && !tmr_busy &&
                (state_q == ST_ARR || (state_q == ST_WBUF &&
                 (opc_q == `SFB_OP_THRU_B1 || opc_q == `SFB_OP_THRU_B2)))) begin
               tmr_start_q   <= 1'b1;
               arr_start_out <= 1'b1;
               arr_buf_out   <= bsel_q;
               arr_page_out  <= page_q;
               case (opc_q)
                  `SFB_OP_PGM_B1, `SFB_OP_PGM_B2: begin
                     arr_op_out   <= `SFB_ARR_PGM;
                     tmr_cycles_q <= P_CYCLES;
                  end
                  `SFB_OP_PAGE_ERA: begin
                     arr_op_out   <= `SFB_ARR_PAGE_ERA;
                     tmr_cycles_q <= PE_CYCLES;
                  end
                  `SFB_OP_BLK_ERA: begin
                     arr_op_out   <= `SFB_ARR_BLK_ERA;
                     arr_page_out <= {page_q[`SFB_BLK_LSB - `SFB_PAGE_LSB +: 7], 3'b000};
                     tmr_cycles_q <= BE_CYCLES;
                  end
                  default: begin
                     arr_op_out   <= `SFB_ARR_PGM_ERA;
                     tmr_cycles_q <= EP_CYCLES;
                  end
               endcase
            end
         end else if (cs_fall) begin
            // a new command always begins here
            state_q   <= ST_OPC;
            bit_cnt_q <= 6'd0;
            out_idx_q <= 3'd0;
         end else if (!cs_n_lvl) begin
            // shift input on rising clock edges
            if (sck_rise && bit_cnt_q != `SFB_RD_DATA_BIT) begin
               bit_cnt_q <= bit_cnt_q + 6'd1;
               sr_q      <= {sr_q[22:0], si_lvl};
            end
            // hold the page once the address ends; write data shifts on behind it
            if (sck_rise && bit_cnt_q == `SFB_ADDR_END - 6'd1) begin
               page_q <= sr_q[`SFB_PAGE_LSB - 1 +: 10];
            end
            case (state_q)
               ST_OPC: begin
                  if (sck_rise) begin
                     opc_q <= opc_next;
                     if (bit_cnt_q == `SFB_OPC_BITS - 6'd1) begin
                        state_q <= opc_state(opc_next);
                        bsel_q  <= buf_of(opc_next);
                     end
                  end
               end
               ST_RBUF: begin
                  // starting byte address sits in the last nine address bits
                  if (sck_rise && bit_cnt_q == `SFB_ADDR_END - 6'd1) begin
                     baddr_q <= {sr_q[7:0], si_lvl};
                  end
                  if (sck_fall && bit_cnt_q == `SFB_RD_DATA_BIT) begin
                     out_on_q <= 1'b1;
                     if (out_idx_q == 3'd0) begin
                        so_out     <= rd_data_q[7];
                        out_byte_q <= rd_data_q;
                        baddr_q    <= next_addr(baddr_q);
                     end else begin
                        so_out <= out_byte_q[3'd7 - out_idx_q];
                     end
                     out_idx_q <= out_idx_q + 3'd1;
                  end
               end
               ST_STAT: begin
                  if (sck_fall && bit_cnt_q >= `SFB_OPC_BITS) begin
                     out_on_q <= 1'b1;
                     if (out_idx_q == 3'd0) begin
                        // fresh snapshot at each pass through bit 7
                        out_byte_q <= status;
                        so_out     <= status[`SFB_ST_READY];
                        show_rdy_q <= 1'b1;
                     end else begin
                        so_out     <= out_byte_q[3'd7 - out_idx_q];
                        show_rdy_q <= 1'b0;
                     end
                     out_idx_q <= out_idx_q + 3'd1;
                  end else if (show_rdy_q) begin
                     // clock parked after bit 7: follow ready live
                     so_out <= status[`SFB_ST_READY];
                  end
               end
               ST_WBUF: begin
                  if (sck_rise && bit_cnt_q == `SFB_ADDR_END - 6'd1) begin
                     baddr_q <= {sr_q[7:0], si_lvl};
                  end
                  // byte stored by the memory process; step and rearm
                  if (sck_rise && bit_cnt_q == `SFB_RD_DATA_BIT - 6'd1) begin
                     baddr_q   <= next_addr(baddr_q);
                     bit_cnt_q <= `SFB_ADDR_END;
                  end
               end
               default: begin
                  // array frames collect address; ignored frames stay silent
                  out_on_q <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ---- sfb_top_properties.sv ----
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module sfb_top_properties #(
   parameter [31:0] MAX_BUSY = 32'd2000
) (
   input wire       ref_clk_in,
   input wire       reset_n_in,
   input wire       cs_n_in,
   input wire       so_oe_out,
   input wire       arr_start_out,
   input wire [2:0] arr_op_out,
   input wire [9:0] arr_page_out,
   input wire       busy_out
);
   reg [31:0] busy_cnt_q;
   wire [31:0] busy_cnt_d;

   // ---------------------------------------------------------
   // helper: length of the current busy stretch
   // ---------------------------------------------------------
   assign busy_cnt_d = busy_out ? busy_cnt_q + 32'd1 : 32'd0;
   always @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         busy_cnt_q <= 32'd0;
      end else begin
         busy_cnt_q <= busy_cnt_d;
      end
   end

   // ---------------------------------------------------------
   // assertions
   // ---------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   // deselect floats the output within the sync delay
   oe_float_a: assert property (cs_n_in [*8] |-> !so_oe_out)
      else $error("output still driven while deselected");
   start_pulse_a: assert property (arr_start_out |=> !arr_start_out)
      else $error("array start longer than one cycle");
   start_busy_a: assert property (arr_start_out |-> ##2 busy_out)
      else $error("no busy after array start");
   busy_cause_a: assert property ($rose(busy_out) |-> $past(arr_start_out, 2))
      else $error("busy without array start");
   start_idle_a: assert property (arr_start_out |-> !busy_out && cs_n_in)
      else $error("start while busy or selected");
   op_code_a: assert property (arr_start_out |-> arr_op_out >= 3'h1 && arr_op_out <= 3'h4)
      else $error("array start with no operation");
   block_align_a: assert property (arr_start_out && arr_op_out == 3'h4
      |-> arr_page_out[2:0] == 3'h0)
      else $error("block erase page not aligned");
   busy_len_a: assert property (busy_out |-> busy_cnt_q <= MAX_BUSY + 32'd2)
      else $error("busy longer than longest operation");
endmodule

// ---- sfb_host_model.sv ----
// host side serial bus master model, mode 0
`timescale 1ns/1ps
module sfb_host_model (
   input  wire ref_clk_in,
   input  wire so_in,
   input  wire so_oe_in,
   output reg  cs_n_out,
   output reg  sck_out,
   output reg  si_out
);
   reg  flt_q = 1'b0;
   wire so_line;

   // a released line toggles so a float never reads as data
   assign so_line = so_oe_in ? so_in : flt_q;
   always @(posedge ref_clk_in) begin
      flt_q <= ~flt_q;
   end

   initial begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      si_out = 1'b0;
   end

   task wait_clk(input integer n);
      repeat (n) @(negedge ref_clk_in);
   endtask

   // select falls before the first bit, stays low to the end
   task sel(input logic low);
      wait_clk(10);
      cs_n_out = ~low;
      wait_clk(10);
   endtask

   // one byte msb first; rx is what the device shows in the low phases
   task xbyte(input [7:0] tx, output [7:0] rx);
      integer i;
      for (i = 7; i >= 0; i = i - 1) begin
         si_out = tx[i];
         wait_clk(20);
         rx[i] = so_line;
         sck_out = 1'b1;
         wait_clk(20);
         sck_out = 1'b0;
      end
   endtask
endmodule

// ---- testbench.sv ----
// self-checking bench for the flash buffer command sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done = checks_done + 1; if ((a) !== (e)) begin \
   fail_count = fail_count + 1; \
   $display("mismatch at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
   localparam [3:0] DENS = 4'ha;
   reg        ref_clk = 1'b0;
   reg        reset_n;
   reg        cmp_done;
   reg        cmp_mis;
   reg        abuf_sel;
   reg  [8:0] abuf_addr;
   wire       cs_n, sck, si, so, so_oe, astart, abuf, busy;
   wire [7:0] abuf_data;
   wire [2:0] aop;
   wire [9:0] apage;
   integer    fail_count = 0;
   integer    checks_done = 0;
   integer    starts = 0;
   integer    j;
   reg  [2:0] got_op;
   reg  [9:0] got_page;
   reg        got_buf;
   reg  [7:0] rx;

   always #2 ref_clk = ~ref_clk;

   sfb_top #(.EP_CYCLES(32'd2000), .P_CYCLES(32'd1500), .PE_CYCLES(32'd1000),
      .BE_CYCLES(32'd1200), .DENSITY_CODE(DENS)) i_sfb_top (
      .ref_clk_in(ref_clk), .reset_n_in(reset_n), .cs_n_in(cs_n), .sck_in(sck),
      .si_in(si), .so_out(so), .so_oe_out(so_oe), .cmp_done_in(cmp_done),
      .cmp_mismatch_in(cmp_mis), .arr_buf_addr_in(abuf_addr), .arr_buf_sel_in(abuf_sel),
      .arr_buf_data_out(abuf_data), .arr_start_out(astart), .arr_op_out(aop),
      .arr_page_out(apage), .arr_buf_out(abuf), .busy_out(busy));
   sfb_host_model u_host (.ref_clk_in(ref_clk), .so_in(so), .so_oe_in(so_oe),
      .cs_n_out(cs_n), .sck_out(sck), .si_out(si));

   // capture what each array start asks for
   always @(posedge ref_clk) begin
      if (astart === 1'b1) begin
         starts <= starts + 1;
         got_op <= aop;
         got_page <= apage;
         got_buf <= abuf;
      end
   end

   function [7:0] pat(input [8:0] a, input integer k);
      pat = a[7:0] + k[7:0] + 8'h3c;
   endfunction

   function [8:0] wrap(input [8:0] a, input integer k);
      wrap = (a + k >= 264) ? a + k - 264 : a + k;
   endfunction

   task test_done;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // status twice in one frame; the repeat must carry the same byte
   task stat_chk(input [7:0] op, input [7:0] exp);
      u_host.sel(1);
      u_host.xbyte(op, rx);
      u_host.xbyte(8'h00, rx);
      `CHK(rx, exp)
      u_host.xbyte(8'h00, rx);
      `CHK(rx, exp)
      u_host.sel(0);
   endtask

   // write three bytes from a, wrapping after 263, check the array port, read them back
   task buf_chk(input [7:0] wop, input [7:0] rop, input sel, input [8:0] a);
      integer k;
      u_host.sel(1);
      u_host.xbyte(wop, rx);
      u_host.xbyte(8'h00, rx);
      u_host.xbyte({7'h00, a[8]}, rx);
      u_host.xbyte(a[7:0], rx);
      for (k = 0; k < 3; k = k + 1) u_host.xbyte(pat(a, k), rx);
      u_host.sel(0);
      for (k = 0; k < 3; k = k + 1) begin
         @(negedge ref_clk);
         abuf_sel = sel;
         abuf_addr = wrap(a, k);
         @(negedge ref_clk);
         `CHK(abuf_data, pat(a, k))
      end
      u_host.sel(1);
      u_host.xbyte(rop, rx);
      u_host.xbyte(8'h00, rx);
      u_host.xbyte({7'h00, a[8]}, rx);
      u_host.xbyte(a[7:0], rx);
      u_host.xbyte(8'h00, rx);
      for (k = 0; k < 3; k = k + 1) begin
         u_host.xbyte(8'h00, rx);
         `CHK(rx, pat(a, k))
      end
      u_host.sel(0);
      `CHK(so_oe, 1'b0)
   endtask

   // array command, then park the clock after ready and wait for it to rise
   task arr_chk(input [7:0] op, input [3:0] e);
      integer n, w;
      reg [23:0] ad;
      n = starts;
      ad = (op == 8'h50) ? 24'h055000 : 24'h054a00;
      u_host.sel(1);
      u_host.xbyte(op, rx);
      u_host.xbyte(ad[23:16], rx);
      u_host.xbyte(ad[15:8], rx);
      u_host.xbyte(ad[7:0], rx);
      if (op == 8'h82 || op == 8'h85) u_host.xbyte(8'ha5, rx);
      u_host.sel(0);
      `CHK(starts, n + 1)
      `CHK({got_buf, got_op}, e)
      `CHK(got_page, (op == 8'h50) ? 10'h2a8 : 10'h2a5)
      u_host.sel(1);
      u_host.xbyte(8'hd7, rx);
      u_host.wait_clk(10);
      `CHK(u_host.so_line, 1'b0)
      w = 0;
      while (u_host.so_line !== 1'b1 && w < 3000) begin
         @(negedge ref_clk);
         w = w + 1;
      end
      `CHK(u_host.so_line, 1'b1)
      u_host.sel(0);
   endtask

   // ---------------------------------------------------------
   // main sequence; the next array op waits for ready
   // ---------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      cmp_done = 1'b0;
      cmp_mis = 1'b0;
      abuf_sel = 1'b0;
      abuf_addr = 9'h000;
      repeat (4) @(negedge ref_clk);
      reset_n = 1'b1;
      stat_chk(8'h57, {2'b10, DENS, 2'b00});
      buf_chk(8'h84, 8'h54, 1'b0, 9'd262);
      buf_chk(8'h87, 8'h56, 1'b1, 9'd263);
      buf_chk(8'h84, 8'hd4, 1'b0, 9'd5);
      buf_chk(8'h87, 8'hd6, 1'b1, 9'd0);
      // program order keeps an erase before each plain program
      arr_chk(8'h81, 4'h3);
      arr_chk(8'h88, 4'h2);
      arr_chk(8'h83, 4'h1);
      arr_chk(8'h86, 4'h9);
      arr_chk(8'h81, 4'h3);
      arr_chk(8'h89, 4'ha);
      arr_chk(8'h50, 4'h4);
      arr_chk(8'h82, 4'h1);
      arr_chk(8'h85, 4'h9);
      for (j = 1; j >= 0; j = j - 1) begin
         @(negedge ref_clk);
         cmp_mis = j[0];
         cmp_done = 1'b1;
         @(negedge ref_clk);
         cmp_done = 1'b0;
         stat_chk(8'hd7, {1'b1, j[0], DENS, 2'b00});
      end
      // unknown opcode leaves the line released
      u_host.sel(1);
      u_host.xbyte(8'hff, rx);
      u_host.xbyte(8'h00, rx);
      `CHK(so_oe, 1'b0)
      u_host.sel(0);
      // erase cut short after one address byte starts nothing
      j = starts;
      u_host.sel(1);
      u_host.xbyte(8'h81, rx);
      u_host.xbyte(8'h05, rx);
      u_host.sel(0);
      `CHK(starts, j)
      `CHK(busy, 1'b0)
      test_done;
   end

   // watchdog well past the expected run length
   initial begin
      #360000;
      fail_count = fail_count + 1;
      test_done;
   end
endmodule

bind sfb_top sfb_top_properties #(.MAX_BUSY(EP_CYCLES)) u_props (
   .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cs_n_in(cs_n_in),
   .so_oe_out(so_oe_out), .arr_start_out(arr_start_out), .arr_op_out(arr_op_out),
   .arr_page_out(arr_page_out), .busy_out(busy_out));
